// File: rtl/abtc_cfg.svh
`ifndef ABTC_CFG_SVH
`define ABTC_CFG_SVH
// ---------------------------------------------------------------------------
// Bus geometry
// ---------------------------------------------------------------------------
`define ABTC_ADDR_W 18
`define ABTC_DATA_W 16
`define ABTC_BYTE_W 8
// Cycle type codes on the two control lines, {bit1, bit0}
`define ABTC_CT_WORD_READ 2'h0
`define ABTC_CT_READ_PAUSE 2'h1
`define ABTC_CT_WORD_WRITE 2'h2
`define ABTC_CT_BYTE_WRITE 2'h3
// Vector alignment mask: bits 1..0 must be zero
`define ABTC_VEC_ALIGN_MASK 16'h0003
// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define ABTC_CLK_PERIOD_NS 4
// Least address setup before the master strobe, in ns
`define ABTC_ADDR_SETUP_NS 150
`define ABTC_ADDR_SETUP_CYC \
  ((`ABTC_ADDR_SETUP_NS + `ABTC_CLK_PERIOD_NS - 1) / `ABTC_CLK_PERIOD_NS)
// Slave response timeout, in ns
`define ABTC_TIMEOUT_NS 10000
`define ABTC_TIMEOUT_CYC (`ABTC_TIMEOUT_NS / `ABTC_CLK_PERIOD_NS)
`endif

// File: rtl/abtc_pkg.sv
package abtc_pkg;
  typedef enum logic [2:0] {
    ABTC_OP_READ,
    ABTC_OP_READ_PAUSE,
    ABTC_OP_WORD_WRITE,
    ABTC_OP_BYTE_WRITE,
    ABTC_OP_VECTOR
  } abtc_op_type;

  typedef enum {
    ABTC_ST_IDLE,
    ABTC_ST_SETUP,
    ABTC_ST_STROBE,
    ABTC_ST_RELEASE
  } abtc_state_type;
endpackage : abtc_pkg

// File: rtl/abtc_od_pin.sv
`timescale 1ns/1ps
`include "abtc_cfg.svh"
// Open-collector drive for a group of low-true lines: asserting a line
// means pulling it low, so only the enable carries information.
module abtc_od_pin #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_assert,
  output logic [WIDTH-1:0] o_pin_out,
  output logic [WIDTH-1:0] o_pin_oe_n
);
  initial begin
    if (WIDTH < 1) begin
      $error("abtc_od_pin: WIDTH must be at least 1");
    end
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_line
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          o_pin_oe_n[g] <= 1'b1;
        end else begin
          o_pin_oe_n[g] <= ~i_assert[g];
        end
      end
      always_ff @(posedge i_clk_sys) begin
        o_pin_out[g] <= 1'b0;
      end
    end
  endgenerate
endmodule : abtc_od_pin

// File: rtl/abtc_master.sv
`timescale 1ns/1ps
`include "abtc_cfg.svh"
// Overview of operation
// - Word read fetches full 16-bit slave word
// - Byte read uses word read, master picks
// - Word writes aimed at even addresses
// - Read-pause returns word, announces following write
// - Vector write uses dedicated line, reaches processor
// - Vectors 000000-000774, ending in 0 or 4; code flags bits 1..0 only, range unchecked
// - L signals true low, H signals true high
// - Lines driven only through open collector
// - Bus has 56 lines of defined groups
// - Grant lines daisy chained, active high
// - Address before master strobe; slave acks untimed
// - Low byte even, high byte odd, unshifted
// - Reads drop bit zero; byte writes drive it
module abtc_master #(
  parameter int ADDR_W = `ABTC_ADDR_W,
  parameter int DATA_W = `ABTC_DATA_W,
  parameter int SETUP_CYC = `ABTC_ADDR_SETUP_CYC,
  parameter int TIMEOUT_CYC = `ABTC_TIMEOUT_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // User request side
  input wire logic i_req_valid,
  input wire logic [2:0] i_req_op,
  input wire logic [ADDR_W-1:0] i_req_addr,
  input wire logic [DATA_W-1:0] i_req_wdata,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [DATA_W-1:0] o_rsp_rdata,
  output logic o_rsp_timeout,
  output logic o_rsp_parity_err,
  output logic o_vec_misaligned,
  output logic o_pause_open,
  // Bus lines, open collector, low-true
  output logic [ADDR_W-1:0] o_addr_out,
  output logic [ADDR_W-1:0] o_addr_oe_n,
  input wire logic [DATA_W-1:0] i_data_in,
  output logic [DATA_W-1:0] o_data_out,
  output logic [DATA_W-1:0] o_data_oe_n,
  output logic [1:0] o_cycle_type_out,
  output logic [1:0] o_cycle_type_oe_n,
  output logic o_master_sync_strobe_out,
  output logic o_master_sync_strobe_oe_n,
  output logic o_vector_write_strobe_out,
  output logic o_vector_write_strobe_oe_n,
  input wire logic i_slave_sync_ack,
  input wire logic i_parity_line_a,
  input wire logic i_parity_line_b
);
  // -------------------------------------------------------------------------
  // Elaboration checks
  // -------------------------------------------------------------------------
  initial begin
    if (ADDR_W != `ABTC_ADDR_W || DATA_W != `ABTC_DATA_W) begin
      $error("abtc_master: bus widths are fixed at 18 and 16");
    end
    if (SETUP_CYC < 1 || TIMEOUT_CYC < 2) begin
      $error("abtc_master: SETUP_CYC >= 1 and TIMEOUT_CYC >= 2");
    end
  end

  localparam int CNT_W = $clog2(TIMEOUT_CYC + SETUP_CYC + 1);

  abtc_pkg::abtc_state_type state_q;
  logic [CNT_W-1:0] cnt_q;
  abtc_pkg::abtc_op_type op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [1:0] ctype_q;
  logic msync_q;
  logic intr_q;
  logic drive_addr_q;
  logic drive_data_q;
  logic pause_q;
  logic [ADDR_W-1:0] pause_addr_q;
  logic [ADDR_W-1:0] addr_assert;
  logic [DATA_W-1:0] data_assert;
  logic [1:0] ctype_assert;
  logic is_read;
  logic acc_ok;
  abtc_pkg::abtc_op_type req_op;

  assign req_op = abtc_pkg::abtc_op_type'(i_req_op);
  // Under an open read-pause only the matching write may go out
  assign acc_ok = !pause_q ||
    ((req_op == abtc_pkg::ABTC_OP_WORD_WRITE ||
      req_op == abtc_pkg::ABTC_OP_BYTE_WRITE) &&
     i_req_addr[ADDR_W-1:1] == pause_addr_q[ADDR_W-1:1]);
  assign is_read = (op_q == abtc_pkg::ABTC_OP_READ) ||
    (op_q == abtc_pkg::ABTC_OP_READ_PAUSE);

  // -------------------------------------------------------------------------
  // Cycle sequencer
  // -------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_q <= abtc_pkg::ABTC_ST_IDLE;
      cnt_q <= '0;
      op_q <= abtc_pkg::ABTC_OP_READ;
      addr_q <= '0;
      wdata_q <= '0;
      ctype_q <= 2'h0;
      msync_q <= 1'b0;
      intr_q <= 1'b0;
      drive_addr_q <= 1'b0;
      drive_data_q <= 1'b0;
    end else begin
      case (state_q)
        abtc_pkg::ABTC_ST_IDLE: begin
          if (i_req_valid && acc_ok) begin
            op_q <= req_op;
            wdata_q <= i_req_wdata;
            cnt_q <= CNT_W'(SETUP_CYC);
            state_q <= abtc_pkg::ABTC_ST_SETUP;
            case (req_op)
              abtc_pkg::ABTC_OP_READ: begin
                ctype_q <= `ABTC_CT_WORD_READ;
                addr_q <= {i_req_addr[ADDR_W-1:1], 1'b0};
                drive_addr_q <= 1'b1;
                drive_data_q <= 1'b0;
              end
              abtc_pkg::ABTC_OP_READ_PAUSE: begin
                ctype_q <= `ABTC_CT_READ_PAUSE;
                addr_q <= {i_req_addr[ADDR_W-1:1], 1'b0};
                drive_addr_q <= 1'b1;
                drive_data_q <= 1'b0;
              end
              abtc_pkg::ABTC_OP_WORD_WRITE: begin
                ctype_q <= `ABTC_CT_WORD_WRITE;
                addr_q <= {i_req_addr[ADDR_W-1:1], 1'b0};
                drive_addr_q <= 1'b1;
                drive_data_q <= 1'b1;
              end
              abtc_pkg::ABTC_OP_BYTE_WRITE: begin
                ctype_q <= `ABTC_CT_BYTE_WRITE;
                addr_q <= i_req_addr;
                drive_addr_q <= 1'b1;
                drive_data_q <= 1'b1;
                // Same byte on both lanes; slave keeps the selected one
                wdata_q <= {2{i_req_wdata[`ABTC_BYTE_W-1:0]}};
              end
              default: begin
                // Vector write: no address, the line selects the processor
                ctype_q <= `ABTC_CT_WORD_READ;
                addr_q <= '0;
                drive_addr_q <= 1'b0;
                drive_data_q <= 1'b1;
              end
            endcase
          end
        end
        abtc_pkg::ABTC_ST_SETUP: begin
          if (cnt_q <= CNT_W'(1)) begin
            // Address has settled; now raise the strobe
            if (op_q == abtc_pkg::ABTC_OP_VECTOR) begin
              intr_q <= 1'b1;
            end else begin
              msync_q <= 1'b1;
            end
            cnt_q <= CNT_W'(TIMEOUT_CYC);
            state_q <= abtc_pkg::ABTC_ST_STROBE;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        abtc_pkg::ABTC_ST_STROBE: begin
          // No fixed delay: wait for the slave ack or give up
          if (i_slave_sync_ack || cnt_q <= CNT_W'(1)) begin
            msync_q <= 1'b0;
            intr_q <= 1'b0;
            drive_data_q <= 1'b0;
            state_q <= abtc_pkg::ABTC_ST_RELEASE;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        abtc_pkg::ABTC_ST_RELEASE: begin
          // Hold address until the slave lets go of its ack
          if (!i_slave_sync_ack) begin
            drive_addr_q <= 1'b0;
            ctype_q <= 2'h0;
            state_q <= abtc_pkg::ABTC_ST_IDLE;
          end
        end
        default: begin
          state_q <= abtc_pkg::ABTC_ST_IDLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Read-pause tracking
  // -------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pause_q <= 1'b0;
      pause_addr_q <= '0;
    end else if (state_q == abtc_pkg::ABTC_ST_STROBE && i_slave_sync_ack)
    begin
      if (op_q == abtc_pkg::ABTC_OP_READ_PAUSE) begin
        pause_q <= 1'b1;
        pause_addr_q <= addr_q;
      end else if (!is_read) begin
        pause_q <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Response to the user
  // -------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_rsp_valid <= 1'b0;
      o_rsp_rdata <= '0;
      o_rsp_timeout <= 1'b0;
      o_rsp_parity_err <= 1'b0;
      o_vec_misaligned <= 1'b0;
      o_req_ready <= 1'b0;
      o_pause_open <= 1'b0;
    end else begin
      o_rsp_valid <= 1'b0;
      o_req_ready <= (state_q == abtc_pkg::ABTC_ST_IDLE) &&
        !(i_req_valid && acc_ok);
      o_pause_open <= pause_q;
      if (state_q == abtc_pkg::ABTC_ST_STROBE &&
          (i_slave_sync_ack || cnt_q <= CNT_W'(1))) begin
        o_rsp_valid <= 1'b1;
        o_rsp_timeout <= !i_slave_sync_ack;
        // Full word returned; user picks the byte by address bit 0
        o_rsp_rdata <= is_read ? i_data_in : '0;
        o_rsp_parity_err <= is_read && i_slave_sync_ack &&
          (i_parity_line_a || i_parity_line_b);
        // Flag only; the processor does not check the value
        o_vec_misaligned <= (op_q == abtc_pkg::ABTC_OP_VECTOR) &&
          ((wdata_q & `ABTC_VEC_ALIGN_MASK) != 16'h0000);
      end
    end
  end

  // -------------------------------------------------------------------------
  // Open-collector line drivers
  // -------------------------------------------------------------------------
  assign addr_assert = drive_addr_q ? addr_q : '0;
  assign data_assert = drive_data_q ? wdata_q : '0;
  assign ctype_assert = drive_addr_q ? ctype_q : 2'h0;

  abtc_od_pin #(.WIDTH(ADDR_W)) u_addr (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_assert(addr_assert),
    .o_pin_out(o_addr_out),
    .o_pin_oe_n(o_addr_oe_n)
  );
  abtc_od_pin #(.WIDTH(DATA_W)) u_data (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_assert(data_assert),
    .o_pin_out(o_data_out),
    .o_pin_oe_n(o_data_oe_n)
  );
  abtc_od_pin #(.WIDTH(2)) u_ctype (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_assert(ctype_assert),
    .o_pin_out(o_cycle_type_out),
    .o_pin_oe_n(o_cycle_type_oe_n)
  );
  abtc_od_pin #(.WIDTH(2)) u_strobes (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_assert({intr_q, msync_q}),
    .o_pin_out({o_vector_write_strobe_out, o_master_sync_strobe_out}),
    .o_pin_oe_n({o_vector_write_strobe_oe_n, o_master_sync_strobe_oe_n})
  );
endmodule : abtc_master

// File: tb/abtc_master_checker.sv
`timescale 1ns/1ps
module abtc_master_checker #(
  parameter int TIMEOUT_CYC = 2500
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic o_rsp_valid,
  input wire logic [17:0] o_addr_out,
  input wire logic [17:0] o_addr_oe_n,
  input wire logic [15:0] o_data_oe_n,
  input wire logic [1:0] o_cycle_type_oe_n,
  input wire logic o_master_sync_strobe_oe_n,
  input wire logic o_vector_write_strobe_oe_n,
  input wire logic i_slave_sync_ack
);
  // ------------------------------------------------------------
  // Handshake and line checks
  // ------------------------------------------------------------
  // Margin covers the ack sample edge and the release edge
  localparam int STROBE_MAX = TIMEOUT_CYC + 2;
  // Counter instead of a delay range: the default timeout is far too long
  // for a range to unroll
  logic [15:0] strobe_cnt_q;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || o_master_sync_strobe_oe_n) begin
      strobe_cnt_q <= 16'h0000;
    end else begin
      strobe_cnt_q <= strobe_cnt_q + 16'h0001;
    end
  end
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  a_only_pull_low: assert property (
    o_addr_out == 18'h0)
    else $error("Address line driven high");
  a_addr_before_strobe: assert property (
    $fell(o_master_sync_strobe_oe_n) |-> $stable(o_addr_oe_n)
      && $stable(o_cycle_type_oe_n))
    else $error("Address moved at strobe");
  a_addr_held: assert property (
    !o_master_sync_strobe_oe_n |=> $stable(o_addr_oe_n))
    else $error("Address moved under strobe");
  a_ack_to_resp: assert property (
    $rose(i_slave_sync_ack) && !o_master_sync_strobe_oe_n
      |=> o_rsp_valid ##1 o_master_sync_strobe_oe_n)
    else $error("Ack not answered next cycle");
  a_strobe_bound: assert property (
    int'(strobe_cnt_q) <= STROBE_MAX)
    else $error("Strobe held past timeout");
  a_word_even: assert property (
    !o_master_sync_strobe_oe_n && o_cycle_type_oe_n != 2'h0
      |-> o_addr_oe_n[0])
    else $error("Low address bit on word cycle");
  a_read_no_data: assert property (
    !o_master_sync_strobe_oe_n && o_cycle_type_oe_n[1] |-> &o_data_oe_n)
    else $error("Data driven on read");
  a_byte_lanes: assert property (
    !o_master_sync_strobe_oe_n && o_cycle_type_oe_n == 2'h0
      |-> o_data_oe_n[15:8] == o_data_oe_n[7:0])
    else $error("Byte lanes differ");
  a_vector_alone: assert property (
    !o_vector_write_strobe_oe_n
      |-> o_master_sync_strobe_oe_n && &o_addr_oe_n)
    else $error("Vector cycle not alone");
  a_resp_pulse: assert property (
    o_rsp_valid |=> !o_rsp_valid)
    else $error("Response longer than one cycle");
endmodule : abtc_master_checker
bind abtc_master abtc_master_checker #(.TIMEOUT_CYC(TIMEOUT_CYC))
  abtc_master_checker_inst (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .o_rsp_valid(o_rsp_valid),
  .o_addr_out(o_addr_out), .o_addr_oe_n(o_addr_oe_n),
  .o_data_oe_n(o_data_oe_n), .o_cycle_type_oe_n(o_cycle_type_oe_n),
  .o_master_sync_strobe_oe_n(o_master_sync_strobe_oe_n),
  .o_vector_write_strobe_oe_n(o_vector_write_strobe_oe_n),
  .i_slave_sync_ack(i_slave_sync_ack));

// File: tb/abtc_slave_model.sv
`timescale 1ns/1ps
// Memory slave plus vector sink; released lines read as deasserted
module abtc_slave_model (
  input wire logic i_clk_sys,
  input wire logic [17:0] i_addr,
  input wire logic [1:0] i_ctype,
  input wire logic i_msync,
  input wire logic i_vstrobe,
  input wire logic [15:0] i_data,
  input wire logic [3:0] i_delay,
  input wire logic i_mute,
  input wire logic i_par,
  output logic [15:0] o_data = 16'h0000,
  output logic o_ack = 1'b0,
  output logic o_par = 1'b0,
  output logic [15:0] o_vector = 16'h0000
);
  logic [15:0] mem [0:255] = '{default: 16'h0000};
  logic [7:0] wa;
  logic [7:0] lk = 8'h00;
  logic lock = 1'b0;
  int cnt = 0;
  assign wa = i_addr[8:1];
  always @(posedge i_clk_sys) begin
    if (!i_msync && !i_vstrobe) begin
      o_ack <= 1'b0;
      o_data <= 16'h0000;
      o_par <= 1'b0;
      cnt <= 0;
    end else if (o_ack || i_mute || cnt < int'(i_delay)) begin
      cnt <= cnt + 1;
    end else if (i_vstrobe) begin
      o_ack <= 1'b1;
      o_vector <= i_data;
    end else if (!lock || (i_ctype[1] && wa == lk)) begin
      o_ack <= 1'b1;
      lock <= i_ctype == 2'h1;
      lk <= wa;
      case (i_ctype)
        2'h2: mem[wa] <= i_data;
        2'h3: begin
          if (i_addr[0]) mem[wa][15:8] <= i_data[15:8];
          else mem[wa][7:0] <= i_data[7:0];
        end
        default: begin
          o_data <= mem[wa];
          o_par <= i_par;
        end
      endcase
    end
  end
endmodule : abtc_slave_model

// File: tb/test_async_backplane_transfer_cycles.sv
`timescale 1ns/1ps
module test_async_backplane_transfer_cycles;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_req_valid = 1'b0;
  logic [2:0] i_req_op = 3'h0;
  logic [17:0] i_req_addr = 18'h0;
  logic [15:0] i_req_wdata = 16'h0000;
  logic [3:0] dly = 4'h0;
  logic mute = 1'b0;
  logic par = 1'b0;
  logic rdy, rv, tmo, perr, mis, popen, moe, voe, ack, spar;
  logic [15:0] rd, doe, sdat, vec;
  logic [17:0] aoe;
  logic [1:0] coe;
  // Wired-or of both parties, in true logic levels
  wire [15:0] dbus = ~doe | sdat;
  int n_fail = 0;
  int checks_done = 0;
  int seed = 53;
  int cyc = 0;
  int ref_mem [int];
  always #2 i_clk_sys = ~i_clk_sys;
  abtc_master #(.TIMEOUT_CYC(20)) abtc_master_inst (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req_valid(i_req_valid),
    .i_req_op(i_req_op), .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata),
    .o_req_ready(rdy), .o_rsp_valid(rv), .o_rsp_rdata(rd),
    .o_rsp_timeout(tmo), .o_rsp_parity_err(perr), .o_vec_misaligned(mis),
    .o_pause_open(popen), .o_addr_out(), .o_addr_oe_n(aoe), .i_data_in(dbus),
    .o_data_out(), .o_data_oe_n(doe), .o_cycle_type_out(),
    .o_cycle_type_oe_n(coe), .o_master_sync_strobe_out(),
    .o_master_sync_strobe_oe_n(moe), .o_vector_write_strobe_out(),
    .o_vector_write_strobe_oe_n(voe), .i_slave_sync_ack(ack),
    .i_parity_line_a(spar), .i_parity_line_b(1'b0));
  abtc_slave_model abtc_slave_model_inst (
    .i_clk_sys(i_clk_sys), .i_addr(~aoe), .i_ctype(~coe), .i_msync(~moe),
    .i_vstrobe(~voe), .i_data(dbus), .i_delay(dly), .i_mute(mute),
    .i_par(par), .o_data(sdat), .o_ack(ack), .o_par(spar), .o_vector(vec));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic step;
    @(posedge i_clk_sys);
    #1;
  endtask : step
  // Request held until the answer; valid may rise before idle
  task automatic run(input logic [2:0] op, input logic [17:0] a,
                     input logic [15:0] d);
    int w;
    int e;
    int n;
    w = int'(a[17:1]);
    e = 0;
    n = 0;
    step();
    i_req_op = op;
    i_req_addr = a;
    i_req_wdata = d;
    i_req_valid = 1'b1;
    do begin
      step();
      n++;
    end while (rv !== 1'b1 && n < 400);
    i_req_valid = 1'b0;
    check(16'(rv), 16'h0001);
    if (op < 3'h2) e = ref_mem[w];
    else if (op == 3'h2) ref_mem[w] = int'(d);
    else if (op == 3'h3 && a[0]) ref_mem[w] = ref_mem[w] & 255 | d[7:0] << 8;
    else if (op == 3'h3) ref_mem[w] = ref_mem[w] & 65280 | int'(d[7:0]);
    check(16'(tmo), 16'(mute));
    if (mute) begin
    end else if (op == 3'h4) begin
      check(vec, d);
      check(16'(mis), 16'(d[1:0] != 2'h0));
    end else begin
      check(rd, 16'(e));
      check(16'(perr), 16'(par && op < 3'h2));
      check(abtc_slave_model_inst.mem[a[8:1]], 16'(ref_mem[w]));
      // Pause flag is registered from the tracker, one edge behind rsp
      step();
      check(16'(popen), 16'(op == 3'h1));
    end
  endtask : run
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    logic [2:0] op;
    logic [17:0] a;
    logic [15:0] d;
    logic [15:0] vl [4] = '{16'h0104, 16'h0106, 16'h01fe, 16'h0000};
    repeat (12) @(posedge i_clk_sys);
    #1;
    i_rst_n = 1'b1;
    for (int i = 0; i < 48; i++) begin
      dly = 4'($random(seed) & 7);
      par = 1'($random(seed) & 1);
      op = 3'($random(seed) & 3);
      a = 18'($random(seed) & 511);
      d = 16'($random(seed));
      run(op, a, d);
      if (op == 3'h1) begin
        step();
        i_req_op = 3'h0;
        i_req_valid = 1'b1;
        repeat (8) step();
        check(16'(rv), 16'h0000);
        check(16'(rdy), 16'h0001);
        check(16'(popen), 16'h0001);
        i_req_valid = 1'b0;
        run(3'(2 + (d & 1)), a, ~d);
      end
    end
    foreach (vl[k]) run(3'h4, 18'h0, vl[k]);
    run(3'h4, 18'h0, 16'($random(seed)));
    mute = 1'b1;
    run(3'h0, 18'h2, 16'h0000);
    mute = 1'b0;
    run(3'h0, 18'h2, 16'h0000);
    stop_test();
  end
endmodule : test_async_backplane_transfer_cycles
